// File: rtl/cph_pkg.sv
// shared constants, types and decode helpers for the coprocessor handshake
// What this block does
// - up to four coprocessors claim instructions, 4-bit identifier each
// - only numbers seven to four serve users
// - follower stages invalid while core reset low
// - coprocessor state changes only with wait high or core reset low
// - load opcode after previous cycle was fetch
// - advance stages when current cycle is fetch
// - never decode compressed word pairs as instructions
// - own instruction only when number matches identifier
// - answer early, commit only after strobe low
// - strobe low: execute, coprocessor class, condition passed
// - absent low, busy low: accepted, core proceeds
// - absent low, busy high: core stalls waiting
// - both high means trap; high-low invalid
// - core ignores answers for ordinary instructions
// - instructions from input data bus, main clock
// - interrupt during busy-wait abandons the instruction
// - privileged instruction from user fetch answered absent
// - answers of many coprocessors are ANDed together
package cph_pkg;
    localparam int          CPH_DATA_W     = 32;
    localparam int          CPH_CPID_W     = 4;
    localparam int          CPH_NUM_CP     = 16;
    localparam int          CPH_CPNUM_LSB  = 8;
    localparam int          CPH_CLS_HI     = 27;
    localparam int          CPH_CLS_LO     = 24;
    localparam int          CPH_UNDEF_BIT  = 4;
    localparam int          CPH_NSTAGE     = 2;
    localparam int          CPH_STG_FETCH  = 0;
    localparam int          CPH_STG_DECODE = 1;
    localparam logic [3:0]  CPH_CP_SYSCTL  = 4'hf;
    localparam logic [3:0]  CPH_CP_DEBUG   = 4'he;
    localparam logic [3:0]  CPH_CP_USER_LO = 4'h4;
    localparam logic [3:0]  CPH_CP_USER_HI = 4'h7;
    localparam logic [3:0]  CPH_CLS_SWI    = 4'hf;
    localparam logic [1:0]  CPH_CLS_CP     = 2'h3;
    localparam logic [2:0]  CPH_CLS_UNDEF  = 3'h3;
    localparam logic [31:0] CPH_WORD_RST   = 32'h0000_0000;

    typedef enum logic [2:0] {
        CS_IDLE   = 3'b001,
        CS_STROBE = 3'b010,
        CS_STALL  = 3'b100
    } cph_core_st_t;

    typedef enum logic [1:0] {
        PS_IDLE = 2'b01,
        PS_BUSY = 2'b10
    } cph_cp_st_t;

    function automatic logic cph_is_coproc(input logic [CPH_DATA_W-1:0] w);
        logic [3:0] cls;
        cls = w[CPH_CLS_HI:CPH_CLS_LO];
        return (cls[3:2] == CPH_CLS_CP) && (cls != CPH_CLS_SWI);
    endfunction

    function automatic logic cph_is_undef(input logic [CPH_DATA_W-1:0] w);
        logic [3:0] cls;
        cls = w[CPH_CLS_HI:CPH_CLS_LO];
        return (cls[3:1] == CPH_CLS_UNDEF) && w[CPH_UNDEF_BIT];
    endfunction

    function automatic logic [CPH_CPID_W-1:0] cph_cp_num(input logic [CPH_DATA_W-1:0] w);
        return w[CPH_CPNUM_LSB +: CPH_CPID_W];
    endfunction
endpackage

// File: rtl/cph_if.sv
// signals between the core and its coprocessors
`timescale 1ns/1ps
interface cph_if;
    logic [31:0] instr_data;
    logic        opcode_fetch_n;
    logic        memory_request_n;
    logic        sequential_cycle;
    logic        compressed_state;
    logic        user_access_n;
    logic        wait_stretch_n;
    logic        core_reset_n;
    logic        coproc_instr_strobe_n;
    logic        coproc_absent;
    logic        coproc_busy;

    modport core (
        output opcode_fetch_n,
        output memory_request_n,
        output sequential_cycle,
        output compressed_state,
        output user_access_n,
        output coproc_instr_strobe_n,
        input  coproc_absent,
        input  coproc_busy,
        input  wait_stretch_n,
        input  core_reset_n,
        input  instr_data
    );

    modport coproc (
        input  opcode_fetch_n,
        input  memory_request_n,
        input  sequential_cycle,
        input  compressed_state,
        input  user_access_n,
        input  coproc_instr_strobe_n,
        input  wait_stretch_n,
        input  core_reset_n,
        input  instr_data,
        output coproc_absent,
        output coproc_busy
    );
endinterface

// File: rtl/cph_stage.sv
// one pipeline follower stage: valid flag, instruction word, privilege tag
`timescale 1ns/1ps
module cph_stage (
    input  wire logic                         clock,
    input  wire logic                         arst_n,
    input  wire logic                         clear,
    input  wire logic                         load,
    input  wire logic                         d_valid,
    input  wire logic [cph_pkg::CPH_DATA_W-1:0] d_instr,
    input  wire logic                         d_priv,
    output logic                              q_valid,
    output logic [cph_pkg::CPH_DATA_W-1:0]    q_instr,
    output logic                              q_priv
);
    import cph_pkg::*;

    logic                  valid_ff;
    logic [CPH_DATA_W-1:0] instr_ff;
    logic                  priv_ff;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            valid_ff <= 1'b0;
        end else if (clear) begin
            valid_ff <= 1'b0;
        end else if (load) begin
            valid_ff <= d_valid;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            instr_ff <= CPH_WORD_RST;
            priv_ff  <= 1'b0;
        end else if (load) begin
            instr_ff <= d_instr;
            priv_ff  <= d_priv;
        end
    end

    assign q_valid = valid_ff;
    assign q_instr = instr_ff;
    assign q_priv  = priv_ff;
endmodule

// File: rtl/cph_core_end.sv
// core end: bus cycle qualifiers and the commit strobe with answer handling
`timescale 1ns/1ps
module cph_core_end (
    input  wire logic                           clock,
    input  wire logic                           arst_n,
    cph_if.core                                 link,
    input  wire logic                           fetch_req,
    input  wire logic                           mem_req,
    input  wire logic                           seq_cycle,
    input  wire logic                           compressed_mode,
    input  wire logic                           user_mode,
    input  wire logic                           exec_issue,
    input  wire logic [cph_pkg::CPH_DATA_W-1:0] exec_instr,
    input  wire logic                           cond_pass,
    input  wire logic                           irq_pending,
    output logic                                cp_done,
    output logic                                cp_undef,
    output logic                                cp_abandon,
    output logic                                cp_stall,
    output logic                                cp_bad_resp
);
    import cph_pkg::*;

    cph_core_st_t state_ff;
    logic         opc_n_ff;
    logic         mreq_n_ff;
    logic         seq_ff;
    logic         comp_ff;
    logic         user_n_ff;
    logic         strobe_n_ff;
    logic         done_ff;
    logic         undef_ff;
    logic         abandon_ff;
    logic         bad_ff;
    logic         bus_ok;
    logic         cp_class;

    assign bus_ok   = link.wait_stretch_n;
    assign cp_class = cph_is_coproc(exec_instr) || cph_is_undef(exec_instr);

    // qualifiers change when a bus cycle completes or while core reset is low; reset shows internal cycles
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            opc_n_ff  <= 1'b1;
            mreq_n_ff <= 1'b1;
            seq_ff    <= 1'b1;
            comp_ff   <= 1'b0;
            user_n_ff <= 1'b0;
        end else if (!link.core_reset_n) begin
            opc_n_ff  <= 1'b1;
            mreq_n_ff <= 1'b1;
            seq_ff    <= 1'b1;
            comp_ff   <= 1'b0;
            user_n_ff <= 1'b1;
        end else if (bus_ok) begin
            opc_n_ff  <= !fetch_req;
            mreq_n_ff <= !mem_req;
            seq_ff    <= seq_cycle;
            comp_ff   <= compressed_mode;
            user_n_ff <= !user_mode;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff    <= CS_IDLE;
            strobe_n_ff <= 1'b1;
            done_ff     <= 1'b0;
            undef_ff    <= 1'b0;
            abandon_ff  <= 1'b0;
            bad_ff      <= 1'b0;
        end else begin
            done_ff    <= 1'b0;
            undef_ff   <= 1'b0;
            abandon_ff <= 1'b0;
            bad_ff     <= 1'b0;
            if (!link.core_reset_n) begin
                state_ff    <= CS_IDLE;
                strobe_n_ff <= 1'b1;
            end else if (bus_ok) begin
                case (state_ff)
                    CS_IDLE: begin
                        // ordinary instructions never reach the handshake
                        if (exec_issue && cp_class && cond_pass && !irq_pending) begin
                            strobe_n_ff <= 1'b0;
                            state_ff    <= CS_STROBE;
                        end
                    end
                    CS_STROBE, CS_STALL: begin
                        // answers are sampled only here, so others are ignored
                        case ({link.coproc_absent, link.coproc_busy})
                            2'b00: begin
                                done_ff     <= 1'b1;
                                strobe_n_ff <= 1'b1;
                                state_ff    <= CS_IDLE;
                            end
                            2'b01: begin
                                if (irq_pending) begin
                                    abandon_ff  <= 1'b1;
                                    strobe_n_ff <= 1'b1;
                                    state_ff    <= CS_IDLE;
                                end else begin
                                    state_ff <= CS_STALL;
                                end
                            end
                            2'b11: begin
                                undef_ff    <= 1'b1;
                                strobe_n_ff <= 1'b1;
                                state_ff    <= CS_IDLE;
                            end
                            default: begin
                                // invalid answer is trapped like an absent one
                                bad_ff      <= 1'b1;
                                undef_ff    <= 1'b1;
                                strobe_n_ff <= 1'b1;
                                state_ff    <= CS_IDLE;
                            end
                        endcase
                    end
                    default: begin
                        state_ff    <= CS_IDLE;
                        strobe_n_ff <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign link.opcode_fetch_n        = opc_n_ff;
    assign link.memory_request_n      = mreq_n_ff;
    assign link.sequential_cycle      = seq_ff;
    assign link.compressed_state      = comp_ff;
    assign link.user_access_n         = user_n_ff;
    assign link.coproc_instr_strobe_n = strobe_n_ff;
    assign cp_done                    = done_ff;
    assign cp_undef                   = undef_ff;
    assign cp_abandon                 = abandon_ff;
    assign cp_stall                   = state_ff[2];
    assign cp_bad_resp                = bad_ff;
endmodule

// File: rtl/cph_coproc_end.sv
// coprocessor end: pipeline follower, decode and the absent/busy answer
`timescale 1ns/1ps
module cph_coproc_end #(
    parameter logic [cph_pkg::CPH_CPID_W-1:0] CP_ID     = 4'h4,
    parameter logic                           PRIV_ONLY = 1'b0
) (
    input  wire logic                           clock,
    input  wire logic                           arst_n,
    cph_if.coproc                               link,
    input  wire logic                           exec_ready,
    output logic                                commit,
    output logic [cph_pkg::CPH_DATA_W-1:0]      commit_instr,
    output logic                                abandoned,
    output logic                                busy_waiting,
    output logic                                decode_own
);
    import cph_pkg::*;

    logic                  bus_ok;
    logic                  in_reset;
    logic                  cur_fetch;
    logic                  prev_fetch_ff;
    logic                  prev_priv_ff;
    logic                  load_fetch;
    logic                  advance;
    logic                  id_legal;
    logic                  own;
    logic                  strobe_lo;
    logic                  exec_own_ff;
    logic [CPH_DATA_W-1:0] exec_instr_ff;
    logic                  absent_ff;
    logic                  busy_ff;
    logic                  commit_ff;
    logic [CPH_DATA_W-1:0] commit_instr_ff;
    logic                  abandon_ff;
    logic                  own_ff;
    cph_cp_st_t            state_ff;
    logic                  take_now;

    logic                  stg_valid [CPH_NSTAGE];
    logic [CPH_DATA_W-1:0] stg_instr [CPH_NSTAGE];
    logic                  stg_priv  [CPH_NSTAGE];

    assign bus_ok    = link.wait_stretch_n;
    assign in_reset  = !link.core_reset_n;
    // a fetch in compressed state carries two short words, never tracked
    assign cur_fetch = !link.opcode_fetch_n && !link.memory_request_n
                       && !link.compressed_state;
    assign load_fetch = bus_ok && prev_fetch_ff;
    assign advance    = bus_ok && cur_fetch;
    assign strobe_lo  = !link.coproc_instr_strobe_n;

    // privilege is caught with the fetch request and travels with the word
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prev_fetch_ff <= 1'b0;
            prev_priv_ff  <= 1'b0;
        end else if (in_reset) begin
            prev_fetch_ff <= 1'b0;
            prev_priv_ff  <= 1'b0;
        end else if (bus_ok) begin
            prev_fetch_ff <= cur_fetch;
            prev_priv_ff  <= link.user_access_n;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < CPH_NSTAGE; gi++) begin : g_stage
            logic                  d_valid;
            logic [CPH_DATA_W-1:0] d_instr;
            logic                  d_priv;
            logic                  d_load;
            if (gi == CPH_STG_FETCH) begin : g_fetch
                assign d_valid = 1'b1;
                assign d_instr = link.instr_data;
                assign d_priv  = prev_priv_ff;
                assign d_load  = load_fetch;
            end else begin : g_next
                assign d_valid = stg_valid[gi-1];
                assign d_instr = stg_instr[gi-1];
                assign d_priv  = stg_priv[gi-1];
                assign d_load  = advance;
            end
            cph_stage u_stage (
                .clock   (clock),
                .arst_n  (arst_n),
                .clear   (in_reset),
                .load    (d_load),
                .d_valid (d_valid),
                .d_instr (d_instr),
                .d_priv  (d_priv),
                .q_valid (stg_valid[gi]),
                .q_instr (stg_instr[gi]),
                .q_priv  (stg_priv[gi])
            );
        end
    endgenerate

    // numbers outside the user range never claim anything
    assign id_legal = (CP_ID >= CPH_CP_USER_LO) && (CP_ID <= CPH_CP_USER_HI);

    assign own = stg_valid[CPH_STG_DECODE]
                 && cph_is_coproc(stg_instr[CPH_STG_DECODE])
                 && (cph_cp_num(stg_instr[CPH_STG_DECODE]) == CP_ID)
                 && id_legal
                 && !(PRIV_ONLY && !stg_priv[CPH_STG_DECODE])
                 && !link.compressed_state;

    // answer is shown from the registered copy; both ends sample the same edge
    assign take_now = bus_ok && strobe_lo && exec_own_ff && !absent_ff && !busy_ff;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            exec_own_ff   <= 1'b0;
            exec_instr_ff <= CPH_WORD_RST;
        end else if (in_reset) begin
            exec_own_ff <= 1'b0;
        end else if (bus_ok) begin
            if (advance) begin
                exec_own_ff   <= own;
                exec_instr_ff <= stg_instr[CPH_STG_DECODE];
            end else if (take_now || (state_ff == PS_BUSY && !strobe_lo)) begin
                exec_own_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            own_ff <= 1'b0;
        end else if (in_reset) begin
            own_ff <= 1'b0;
        end else if (bus_ok) begin
            own_ff <= own;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            absent_ff <= 1'b1;
            busy_ff   <= 1'b1;
        end else if (in_reset) begin
            absent_ff <= 1'b1;
            busy_ff   <= 1'b1;
        end else if (bus_ok) begin
            // compressed state waits for a completed bus cycle like everything else
            if (link.compressed_state) begin
                absent_ff <= 1'b1;
                busy_ff   <= 1'b1;
            end else if (exec_own_ff && !take_now && !(state_ff == PS_BUSY && !strobe_lo)) begin
                absent_ff <= 1'b0;
                busy_ff   <= !exec_ready;
            end else begin
                // high default lets several answers be ANDed
                absent_ff <= 1'b1;
                busy_ff   <= 1'b1;
            end
        end
    end

    // interim work while busy stays outside; commits here only on take_now
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff        <= PS_IDLE;
            commit_ff       <= 1'b0;
            commit_instr_ff <= CPH_WORD_RST;
            abandon_ff      <= 1'b0;
        end else begin
            commit_ff  <= 1'b0;
            abandon_ff <= 1'b0;
            if (in_reset) begin
                state_ff <= PS_IDLE;
            end else if (bus_ok) begin
                case (state_ff)
                    PS_IDLE: begin
                        if (take_now) begin
                            commit_ff       <= 1'b1;
                            commit_instr_ff <= exec_instr_ff;
                        end else if (strobe_lo && exec_own_ff && busy_ff && !absent_ff) begin
                            state_ff <= PS_BUSY;
                        end
                    end
                    PS_BUSY: begin
                        if (!strobe_lo) begin
                            abandon_ff <= 1'b1;
                            state_ff   <= PS_IDLE;
                        end else if (take_now) begin
                            commit_ff       <= 1'b1;
                            commit_instr_ff <= exec_instr_ff;
                            state_ff        <= PS_IDLE;
                        end
                    end
                    default: begin
                        state_ff <= PS_IDLE;
                    end
                endcase
            end
        end
    end

    assign link.coproc_absent = absent_ff;
    assign link.coproc_busy   = busy_ff;
    assign commit             = commit_ff;
    assign commit_instr       = commit_instr_ff;
    assign abandoned          = abandon_ff;
    assign busy_waiting       = state_ff[1];
    assign decode_own         = own_ff;
endmodule

// File: tb/cph_link_chk.sv
// concurrent checks on the link between the core end and the coprocessor end
`timescale 1ns/1ps
module cph_link_chk (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic opcode_fetch_n,
    input wire logic memory_request_n,
    input wire logic compressed_state,
    input wire logic wait_stretch_n,
    input wire logic core_reset_n,
    input wire logic coproc_instr_strobe_n,
    input wire logic coproc_absent,
    input wire logic coproc_busy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    inv_resp_a: assert property (!(coproc_absent && !coproc_busy))
        else $error("invalid answer on the link");
    rst_quiet_a: assert property (!core_reset_n [*2] |=> coproc_absent && coproc_busy)
        else $error("answer not absent during core reset");
    rst_core_a: assert property (!core_reset_n |=> coproc_instr_strobe_n
        && opcode_fetch_n && memory_request_n)
        else $error("core not idle during core reset");
    comp_absent_a: assert property (compressed_state && wait_stretch_n
        |=> coproc_absent && coproc_busy)
        else $error("answer not absent in compressed state");
    wait_freeze_a: assert property (!wait_stretch_n && core_reset_n
        |=> $stable(coproc_absent) && $stable(coproc_busy))
        else $error("answer changed in a stretched cycle");
    resp_done_a: assert property (!coproc_instr_strobe_n && !coproc_absent && !coproc_busy
        && wait_stretch_n |=> coproc_instr_strobe_n)
        else $error("strobe held after accept");
    resp_trap_a: assert property (!coproc_instr_strobe_n && coproc_absent
        && wait_stretch_n |=> coproc_instr_strobe_n)
        else $error("strobe held after absent");
    stall_hold_a: assert property (!coproc_instr_strobe_n && !coproc_absent && coproc_busy
        && wait_stretch_n |=> !coproc_absent)
        else $error("absent rose during busy wait");
    abandon_a: assert property ((!coproc_instr_strobe_n && !coproc_absent && coproc_busy)
        ##1 coproc_instr_strobe_n |-> ##[1:3] (coproc_absent && coproc_busy))
        else $error("busy wait not dropped after abandon");
endmodule

// File: tb/coprocessor_pipeline_handshake_bench.sv
// self-checking bench: core end and coprocessor end joined by the link
`timescale 1ns/1ps
module coprocessor_pipeline_handshake_bench;
    import cph_pkg::*;
    logic        clock, arst_n, fetch_req, mem_req, seq_cycle, compressed_mode, user_mode;
    logic        exec_issue, cond_pass, irq_pending, exec_ready;
    logic        cp_done, cp_undef, cp_abandon, cp_bad_resp, commit;
    logic        cp_stall, busy_waiting, abandoned, decode_own, ab_seen;
    logic [31:0] exec_instr, commit_instr;
    logic [3:0]  res_q[$];
    logic [31:0] word_q[$];
    int          miscompares = 0;
    int          num_checks  = 0;
    int          test_n      = 0;
    cph_if lk();
    cph_core_end i_cph_core_end (.clock(clock), .arst_n(arst_n), .link(lk.core),
        .fetch_req(fetch_req), .mem_req(mem_req), .seq_cycle(seq_cycle),
        .compressed_mode(compressed_mode), .user_mode(user_mode), .exec_issue(exec_issue),
        .exec_instr(exec_instr), .cond_pass(cond_pass), .irq_pending(irq_pending),
        .cp_done(cp_done), .cp_undef(cp_undef), .cp_abandon(cp_abandon), .cp_stall(cp_stall),
        .cp_bad_resp(cp_bad_resp));
    cph_coproc_end i_cph_coproc_end (.clock(clock), .arst_n(arst_n), .link(lk.coproc),
        .exec_ready(exec_ready), .commit(commit), .commit_instr(commit_instr),
        .abandoned(abandoned), .busy_waiting(busy_waiting), .decode_own(decode_own));
    cph_link_chk i_cph_link_chk (.clock(clock), .arst_n(arst_n),
        .opcode_fetch_n(lk.opcode_fetch_n), .memory_request_n(lk.memory_request_n),
        .compressed_state(lk.compressed_state), .wait_stretch_n(lk.wait_stretch_n),
        .core_reset_n(lk.core_reset_n), .coproc_instr_strobe_n(lk.coproc_instr_strobe_n),
        .coproc_absent(lk.coproc_absent), .coproc_busy(lk.coproc_busy));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #5;
    endtask
    task automatic check_res(input logic [3:0] exp, input logic [3:0] got);
        num_checks++;
        if (exp !== got) begin
            miscompares++;
            $display("Error at %0t: result expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic check_word(input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (exp !== got) begin
            miscompares++;
            $display("Error at %0t: commit expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // results are {bad, abandon, undef, done}, one-hot except bad which comes with undef; an unexpected one compares to zero
    always @(posedge clock) begin
        if ({cp_bad_resp, cp_abandon, cp_undef, cp_done} !== 4'h0)
            check_res((res_q.size() != 0) ? res_q.pop_front() : 4'h0,
                {cp_bad_resp, cp_abandon, cp_undef, cp_done});
        if (commit === 1'b1)
            check_word((word_q.size() != 0) ? word_q.pop_front() : ~commit_instr,
                commit_instr);
        if (abandoned === 1'b1) ab_seen = 1'b1;
    end
    // wait is stretched at random while the follower fills, never during the handshake
    task automatic fill(input logic [31:0] w, input logic comp);
        compressed_mode = comp;
        fetch_req = 1'b1;
        mem_req = 1'b1;
        lk.instr_data = w;
        for (int i = 0; i < 12; i++) begin
            lk.wait_stretch_n = (i > 7) || ($urandom_range(3) != 0);
            seq_cycle = $urandom_range(1);
            tick(1);
        end
        fetch_req = 1'b0;
        mem_req = 1'b0;
        compressed_mode = 1'b0;
        tick(4);
    endtask
    // mode 0 ready at once, 1 busy then ready, 2 busy then interrupt
    task automatic run(input logic [31:0] w, input logic c, input int mode,
                       input logic rst, input logic [3:0] exp);
        logic own_exp;
        exec_ready = (mode == 0);
        ab_seen = 1'b0;
        fill(w, 1'b0);
        if (rst) begin
            lk.core_reset_n = 1'b0;
            tick(3);
            lk.core_reset_n = 1'b1;
            tick(1);
        end
        // ours: coprocessor class, number four, pipeline not emptied by a core reset
        own_exp = (w[11:8] == 4'h4) && (w[27:26] == 2'h3) && (w[27:24] != 4'hf) && !rst;
        check_res({3'h0, own_exp}, {3'h0, decode_own});
        if (exp != 4'h0) res_q.push_back(exp);
        if (exp == 4'h1) word_q.push_back(w);
        exec_instr = w;
        cond_pass = c;
        exec_issue = 1'b1;
        tick(1);
        exec_issue = 1'b0;
        tick(4);
        if (mode != 0) check_res(4'h3, {2'h0, busy_waiting, cp_stall});
        if (mode == 1) exec_ready = 1'b1;
        if (mode == 2) irq_pending = 1'b1;
        for (int i = 0; i < 40 && res_q.size() != 0; i++) tick(1);
        if (res_q.size() != 0) begin
            miscompares++;
            report_and_stop();
        end
        irq_pending = 1'b0;
        exec_ready = 1'b1;
        tick(6);
        check_res({3'h0, mode == 2}, {3'h0, ab_seen});
        test_n++;
        $display("test %0d finished", test_n);
    endtask
    initial begin
        arst_n = 1'b0;
        {fetch_req, mem_req, seq_cycle, compressed_mode, exec_issue} = 5'h00;
        {cond_pass, irq_pending, exec_ready} = 3'h0;
        user_mode = 1'b1;
        exec_instr = 32'h0000_0000;
        lk.instr_data = 32'h0000_0000;
        lk.wait_stretch_n = 1'b1;
        lk.core_reset_n = 1'b1;
        void'($urandom(32'h0000_8c22));
        tick(5);
        arst_n = 1'b1;
        tick(2);
        run(32'hEE00_0400 | ($urandom & 32'h0000_00ff), 1'b1, 0, 1'b0, 4'h1);
        run(32'hEE00_0500 | ($urandom & 32'h0000_00ff), 1'b1, 0, 1'b0, 4'h2);
        run(32'hEE00_0E00 | ($urandom & 32'h0000_00ff), 1'b1, 0, 1'b0, 4'h2);
        run(32'hE600_0410 | ($urandom & 32'h0000_00ff), 1'b1, 0, 1'b0, 4'h2);
        run(32'hEE00_0400 | ($urandom & 32'h0000_00ff), 1'b1, 1, 1'b0, 4'h1);
        run(32'hEE00_0400 | ($urandom & 32'h0000_00ff), 1'b1, 2, 1'b0, 4'h4);
        run(32'hE000_0400 | ($urandom & 32'h0000_00ff), 1'b1, 0, 1'b0, 4'h0);
        run(32'hEE00_0400 | ($urandom & 32'h0000_00ff), 1'b0, 0, 1'b0, 4'h0);
        fill(32'hEE00_0400, 1'b1);
        run(32'hEE00_0400 | ($urandom & 32'h0000_00ff), 1'b1, 0, 1'b1, 4'h2);
        report_and_stop();
    end
endmodule
